// [rtl/pci_irq_consts.svh]
// offsets, field positions and reset values of the interrupt and status registers
`ifndef PCI_IRQ_CONSTS_SVH
`define PCI_IRQ_CONSTS_SVH

// configuration dword holding latency, grant, pin and line fields
`define CFG_IRQ_OFS 8'h3C
// local memory window offsets
`define STATUS_OFS 12'h100
`define MASK_OFS 12'h104

// fixed configuration field values and the line reset value
`define MAX_LAT_VAL 8'hFF
`define MIN_GNT_VAL 8'h04
`define INT_PIN_VAL 8'h01
`define INT_LINE_RST 8'h00

// reset values of writable and sticky state
`define MASK_RST 24'h000000
`define STATUS_RST 24'h000000
`define PROG_FLAGS_RST 4'h0

// bits that a write of one clears
`define CLEARABLE_BITS 24'h0FF808

// status bit positions
`define PROG_FLAGS_LSB 28
`define RUNNING_BIT 27
`define SYNC_ERR_BIT 19
`define OPCODE_ERR_BIT 18
`define ABORT_BIT 17
`define INSTR_PAR_BIT 16
`define BUS_PAR_BIT 15
`define RESYNC_BIT 14
`define TGT_LAT_BIT 13
`define DROP_BIT 12
`define PROG_IRQ_BIT 11
`define AUDIO_OVF_BIT 3

`endif

// [rtl/pci_irq_pkg.sv]
// types shared by the interrupt and status register files
package pci_irq_pkg;
  typedef logic [31:0] dword_t; // one register word
  typedef logic [3:0] byte_en_n_t; // pci byte enables, active low
  typedef logic [23:0] irq_vec_t; // maskable status bits
  typedef logic [3:0] prog_flags_t; // program status flags
  // kind of register access taken in a cycle
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CFG = 2'b01,
    ACC_MEM = 2'b10
  } acc_kind_e;
endpackage

// [rtl/status_bits_if.sv]
// carrier between the register front end and the sticky status bit array
`timescale 1ns/1ps
interface status_bits_if;
  import pci_irq_pkg::*;
  irq_vec_t set; // event pulses, one per bit
  irq_vec_t clr; // write-one clear strobes
  irq_vec_t mask; // interrupt enables
  irq_vec_t status; // sticky bits
  logic pending; // any enabled bit set
  modport regs (output set, output clr, output mask, input status, input pending);
  modport bits (input set, input clr, input mask, output status, output pending);
endinterface

// [rtl/status_bit_array.sv]
// sticky status bits with write-one clear and masked pending summary
`timescale 1ns/1ps
`include "pci_irq_consts.svh"
module status_bit_array (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // link to the register front end
  status_bits_if.bits sb
);
  import pci_irq_pkg::*;

  localparam irq_vec_t status_rst_val = `STATUS_RST; // reset pattern of the sticky bits

  // one sticky flop per bit, set has priority over clear
  for (genvar i = 0; i < 24; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        sb.status[i] <= status_rst_val[i];
      end else if (sb.set[i]) begin
        sb.status[i] <= 1'b1;
      end else if (sb.clr[i]) begin
        sb.status[i] <= 1'b0;
      end
    end
  end

  // pending level from enabled sticky bits
  assign sb.pending = |(sb.status & sb.mask);

  // set beats a clear in the same cycle
  property p_set_beats_clr;
    @(posedge clk_i) disable iff (srst_i)
    (sb.set & sb.clr) != 24'h000000 |=> (sb.status & $past(sb.set & sb.clr)) == $past(sb.set & sb.clr);
  endproperty
  a_set_beats_clr: assert property (p_set_beats_clr) else $error("set lost to clear");

endmodule // status_bit_array

// [rtl/pci_interrupt_status_regs.sv]
// interrupt, status and configuration registers of the capture function
`timescale 1ns/1ps
`include "pci_irq_consts.svh"
module pci_interrupt_status_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // configuration access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:2] cfg_addr_i,
  // memory window access
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [31:2] ad_i,
  input wire logic [31:12] mem_base_i,
  // shared write data and byte enables
  input wire pci_irq_pkg::byte_en_n_t cbe_n_i,
  input wire pci_irq_pkg::dword_t wdata_i,
  // read answer
  output pci_irq_pkg::dword_t rdata_o,
  output logic rvalid_o,
  // program engine events
  input wire pci_irq_pkg::prog_flags_t prog_set_i,
  input wire pci_irq_pkg::prog_flags_t prog_reset_i,
  input wire logic dma_running_i,
  input wire logic sync_overflow_i,
  input wire logic sync_mismatch_i,
  input wire logic opcode_error_i,
  input wire logic program_irq_i,
  // bus events
  input wire logic master_abort_i,
  input wire logic target_abort_i,
  input wire logic instr_fetch_parity_i,
  input wire logic parity_resp_en_i,
  input wire logic bus_parity_i,
  // fifo and audio events
  input wire logic fifo_resync_i,
  input wire logic fifo_target_latency_i,
  input wire logic fifo_drop_i,
  input wire logic audio_overflow_i,
  // dma stop request
  output logic dma_stop_o,
  // interrupt pin, open drain
  output logic inta_o,
  output logic inta_oe_n_o
);
  import pci_irq_pkg::*;

  status_bits_if sb (); // link to sticky bit array

  acc_kind_e acc_kind; // access taken this cycle
  logic mem_hit; // address falls in our window
  logic [11:0] mem_ofs; // byte offset inside the window
  dword_t lane_mask; // write lanes enabled
  dword_t next_rdata; // read word before the output flop
  logic [7:0] int_line; // routing byte from firmware
  irq_vec_t int_mask; // interrupt enable bits
  prog_flags_t program_status_flags; // program flags
  logic dma_running_flag; // registered dma enable
  irq_vec_t evt; // event pulses into the array
  logic instr_parity_hit; // qualified instruction parity event
  dword_t status_word; // status register as read

  // window decode on the 12-bit offset above the base
  assign mem_hit = (ad_i[31:12] == mem_base_i);
  assign mem_ofs = {ad_i[11:2], 2'b00};

  // classify the request, configuration first
  always_comb begin
    if (cfg_rd_i || cfg_wr_i) begin
      acc_kind = ACC_CFG;
    end else if ((mem_rd_i || mem_wr_i) && mem_hit) begin
      acc_kind = ACC_MEM;
    end else begin
      acc_kind = ACC_IDLE;
    end
  end

  // byte enables widened to bit lanes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[8*b +: 8] = {8{~cbe_n_i[b]}};
  end

  // interrupt line byte, lane 0 only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_line <= `INT_LINE_RST;
    end else if (cfg_wr_i && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS && !cbe_n_i[0]) begin
      int_line <= wdata_i[7:0];
    end
  end

  // interrupt mask, per enabled lane
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_mask <= `MASK_RST;
    end else if (acc_kind == ACC_MEM && mem_wr_i && mem_ofs == `MASK_OFS) begin
      int_mask <= (int_mask & ~lane_mask[23:0]) | (wdata_i[23:0] & lane_mask[23:0]);
    end
  end

  // program flags: set bits beat reset bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      program_status_flags <= `PROG_FLAGS_RST;
    end else begin
      program_status_flags <= prog_set_i | (program_status_flags & ~prog_reset_i);
    end
  end

  // live dma enable mirror
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dma_running_flag <= 1'b0;
    end else begin
      dma_running_flag <= dma_running_i;
    end
  end

  // instruction parity counts only with parity response on
  assign instr_parity_hit = instr_fetch_parity_i && parity_resp_en_i;

  // event pulses mapped onto status bits
  always_comb begin
    evt = 24'h000000;
    evt[`SYNC_ERR_BIT] = sync_overflow_i || sync_mismatch_i;
    evt[`OPCODE_ERR_BIT] = opcode_error_i;
    evt[`ABORT_BIT] = master_abort_i || target_abort_i;
    evt[`INSTR_PAR_BIT] = instr_parity_hit;
    evt[`BUS_PAR_BIT] = bus_parity_i;
    evt[`RESYNC_BIT] = fifo_resync_i;
    evt[`TGT_LAT_BIT] = fifo_target_latency_i;
    evt[`DROP_BIT] = fifo_drop_i;
    evt[`PROG_IRQ_BIT] = program_irq_i;
    evt[`AUDIO_OVF_BIT] = audio_overflow_i;
  end

  // drive the sticky array
  assign sb.set = evt;
  assign sb.mask = int_mask;
  // clear only clearable bits on enabled lanes of a status write
  assign sb.clr = (acc_kind == ACC_MEM && mem_wr_i && mem_ofs == `STATUS_OFS)
    ? (wdata_i[23:0] & lane_mask[23:0] & `CLEARABLE_BITS) : 24'h000000;

  status_bit_array u_bits (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .sb (sb.bits)
  );

  // status word; flag bits above 23 never feed the interrupt
  assign status_word = {program_status_flags, dma_running_flag, 3'b000, sb.status};

  // read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (acc_kind == ACC_CFG && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS) begin
      next_rdata = {`MAX_LAT_VAL, `MIN_GNT_VAL, `INT_PIN_VAL, int_line};
    end else if (acc_kind == ACC_MEM && mem_ofs == `STATUS_OFS) begin
      next_rdata = status_word;
    end else if (acc_kind == ACC_MEM && mem_ofs == `MASK_OFS) begin
      next_rdata = {8'h00, int_mask};
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h00000000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= (acc_kind == ACC_CFG && cfg_rd_i) || (acc_kind == ACC_MEM && mem_rd_i);
      rdata_o <= next_rdata;
    end
  end

  // stop the dma program on fetch parity error while parity response is on
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dma_stop_o <= 1'b0;
    end else begin
      dma_stop_o <= instr_parity_hit;
    end
  end

  // open-drain interrupt, pulled low while enabled bits pend
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      inta_o <= 1'b0;
      inta_oe_n_o <= 1'b1;
    end else begin
      inta_o <= 1'b0;
      inta_oe_n_o <= ~sb.pending;
    end
  end

  // fixed configuration fields on read
  property p_cfg_fixed;
    @(posedge clk_i) disable iff (srst_i)
    cfg_rd_i && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS |=> rvalid_o && rdata_o[31:24] == 8'hFF;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("latency field wrong");

  property p_min_grant;
    @(posedge clk_i) disable iff (srst_i)
    cfg_rd_i && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS |=> rdata_o[23:16] == 8'h04;
  endproperty
  a_min_grant: assert property (p_min_grant) else $error("grant field wrong");

  property p_int_pin;
    @(posedge clk_i) disable iff (srst_i)
    cfg_rd_i && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS |=> rdata_o[15:8] == 8'h01;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("pin field wrong");

  // a line write with lane 0 enabled is stored as written
  property p_int_line;
    @(posedge clk_i) disable iff (srst_i)
    cfg_wr_i && {cfg_addr_i, 2'b00} == `CFG_IRQ_OFS && !cbe_n_i[0] |=> int_line == $past(wdata_i[7:0]);
  endproperty
  a_int_line: assert property (p_int_line) else $error("line byte not stored");

  // unmapped window offsets answer zero
  property p_unmapped;
    @(posedge clk_i) disable iff (srst_i)
    !cfg_rd_i && !cfg_wr_i && mem_rd_i && mem_hit && mem_ofs != `STATUS_OFS && mem_ofs != `MASK_OFS
      |=> rvalid_o && rdata_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // disabled lane 2 of the mask keeps its value
  property p_lane_keep;
    @(posedge clk_i) disable iff (srst_i)
    acc_kind == ACC_MEM && mem_wr_i && mem_ofs == `MASK_OFS && cbe_n_i[2] |=> int_mask[23:16] == $past(int_mask[23:16]);
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("disabled lane changed");

  // write one without an event clears bus parity bit
  property p_w1c;
    @(posedge clk_i) disable iff (srst_i)
    sb.clr[`BUS_PAR_BIT] && !bus_parity_i |=> !sb.status[`BUS_PAR_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  // a plain status read changes nothing
  property p_read_quiet;
    @(posedge clk_i) disable iff (srst_i)
    acc_kind == ACC_MEM && mem_rd_i && !mem_wr_i && evt == 24'h000000 |=> $stable(sb.status);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed status");

  // running bit follows dma enable
  property p_running;
    @(posedge clk_i) disable iff (srst_i)
    1'b1 |=> status_word[27] == $past(dma_running_i);
  endproperty
  a_running: assert property (p_running) else $error("running bit stale");

  // fetch parity error with parity response on sets bit and stops dma next cycle
  property p_dma_stop;
    @(posedge clk_i) disable iff (srst_i)
    instr_fetch_parity_i && parity_resp_en_i |=> dma_stop_o && sb.status[`INSTR_PAR_BIT];
  endproperty
  a_dma_stop: assert property (p_dma_stop) else $error("dma not stopped");

  // abort event sets abort bit
  property p_abort;
    @(posedge clk_i) disable iff (srst_i)
    master_abort_i || target_abort_i |=> sb.status[`ABORT_BIT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");

  // enabled pending bit drives pin within two cycles and holds
  property p_irq_level;
    @(posedge clk_i) disable iff (srst_i)
    (sb.status & int_mask) != 24'h000000 ##1 (sb.status & int_mask) != 24'h000000 |-> !inta_oe_n_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not driven");

  // masked-off status never drives the pin
  property p_irq_quiet;
    @(posedge clk_i) disable iff (srst_i)
    (sb.status & int_mask) == 24'h000000 |=> inta_oe_n_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  // main scenarios
  c_irq_raised: cover property (@(posedge clk_i) disable iff (srst_i) $fell(inta_oe_n_o));
  c_irq_cleared: cover property (@(posedge clk_i) disable iff (srst_i) $rose(inta_oe_n_o));
  c_set_and_clr: cover property (@(posedge clk_i) disable iff (srst_i) (sb.set & sb.clr) != 24'h000000);
  c_cfg_read: cover property (@(posedge clk_i) disable iff (srst_i) cfg_rd_i ##1 rvalid_o);

endmodule // pci_interrupt_status_regs

// [tb/pci_host_model.sv]
// host bridge model issuing configuration and memory register requests
`timescale 1ns/1ps
module pci_host_model (
  // clock
  input wire logic clk_i,
  // request lines toward the device
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [7:2] cfg_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [31:2] ad_o,
  output pci_irq_pkg::byte_en_n_t cbe_n_o,
  output pci_irq_pkg::dword_t wdata_o,
  // read answer from the device
  input wire pci_irq_pkg::dword_t rdata_i,
  input wire logic rvalid_i
);
  import pci_irq_pkg::*;
  // idle bus at time zero
  initial begin
    {cfg_rd_o, cfg_wr_o, mem_rd_o, mem_wr_o} = 4'h0;
    cfg_addr_o = 6'h00;
    ad_o = 30'h0;
    cbe_n_o = 4'hF;
    wdata_o = 32'h0;
  end
  // one request held for one clock, answer taken one clock later
  task automatic xfer(input logic is_cfg, input logic wr, input logic [31:2] addr, input byte_en_n_t be,
                      input dword_t d, output dword_t rd, output logic got);
    @(negedge clk_i);
    cfg_rd_o = is_cfg & ~wr;
    cfg_wr_o = is_cfg & wr;
    mem_rd_o = ~is_cfg & ~wr;
    mem_wr_o = ~is_cfg & wr;
    cfg_addr_o = addr[7:2];
    ad_o = addr;
    cbe_n_o = be;
    wdata_o = d;
    @(negedge clk_i);
    rd = rdata_i;
    got = rvalid_i;
    {cfg_rd_o, cfg_wr_o, mem_rd_o, mem_wr_o} = 4'h0;
    // released lines show the inverse, never a stale value
    cfg_addr_o = ~cfg_addr_o;
    ad_o = ~ad_o;
    cbe_n_o = ~cbe_n_o;
    wdata_o = ~wdata_o;
  endtask
endmodule // pci_host_model

// [tb/pci_interrupt_status_regs_tb_top.sv]
// self-checking bench of the interrupt, status and configuration registers
`timescale 1ns/1ps
`include "pci_irq_consts.svh"
module pci_interrupt_status_regs_tb_top;
  import pci_irq_pkg::*;
  localparam int EV_BIT [12] = '{19, 19, 18, 17, 17, 16, 15, 14, 13, 12, 11, 3}; // status bit per event
  logic clk_i = 1'b0; // 200 MHz clock
  logic srst_i = 1'b1; // reset held at start
  logic cfg_rd, cfg_wr, mem_rd, mem_wr, rvalid, dma_stop, inta, inta_oe_n, got, stop_seen;
  logic [7:2] cfg_addr;
  logic [31:2] ad;
  logic [31:12] base = 20'h0; // memory window base
  byte_en_n_t cbe_n;
  dword_t wdata, rdata, rd_v, rnd;
  prog_flags_t pset = 4'h0, preset = 4'h0, exp_fl = 4'h0;
  logic [11:0] ev = 12'h000; // event pulses
  logic run = 1'b0, resp_en = 1'b0; // dma level and parity response
  irq_vec_t exp_st = 24'h000000; // expected sticky bits
  integer seed = 32'hb5b8;
  int num_errors = 0, n_checks = 0;
  // clock generator
  always #2.5 clk_i = ~clk_i;
  // host side of the register bus
  pci_host_model pci_host_model_i (.clk_i(clk_i), .cfg_rd_o(cfg_rd), .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .ad_o(ad), .cbe_n_o(cbe_n), .wdata_o(wdata), .rdata_i(rdata),
    .rvalid_i(rvalid));
  // device under test
  pci_interrupt_status_regs pci_interrupt_status_regs_i (.clk_i(clk_i), .srst_i(srst_i), .cfg_rd_i(cfg_rd),
    .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .ad_i(ad),
    .mem_base_i(base), .cbe_n_i(cbe_n), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .prog_set_i(pset), .prog_reset_i(preset), .dma_running_i(run), .sync_overflow_i(ev[0]),
    .sync_mismatch_i(ev[1]), .opcode_error_i(ev[2]), .program_irq_i(ev[10]), .master_abort_i(ev[3]),
    .target_abort_i(ev[4]), .instr_fetch_parity_i(ev[5]), .parity_resp_en_i(resp_en), .bus_parity_i(ev[6]),
    .fifo_resync_i(ev[7]), .fifo_target_latency_i(ev[8]), .fifo_drop_i(ev[9]), .audio_overflow_i(ev[11]),
    .dma_stop_o(dma_stop), .inta_o(inta), .inta_oe_n_o(inta_oe_n));
  // expected status word from the bench state
  function automatic dword_t stat_word(irq_vec_t st, prog_flags_t fl, logic r);
    return {fl, r, 3'b000, st & `CLEARABLE_BITS};
  endfunction
  // compare and count
  task automatic check(input string name, input dword_t seen, input dword_t exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // memory window access at a 12-bit offset
  task automatic mem(input logic wr, input logic [11:0] ofs, input byte_en_n_t be, input dword_t d);
    pci_host_model_i.xfer(1'b0, wr, {base, ofs[11:2]}, be, d, rd_v, got);
  endtask
  // configuration dword access
  task automatic cfg(input logic wr, input byte_en_n_t be, input dword_t d);
    pci_host_model_i.xfer(1'b1, wr, 30'h0F, be, d, rd_v, got);
  endtask
  // one-cycle event pulse, expected state updated
  task automatic pulse(input logic [11:0] e, input prog_flags_t s, input prog_flags_t r);
    @(negedge clk_i);
    ev = e;
    pset = s;
    preset = r;
    @(negedge clk_i);
    stop_seen = dma_stop;
    ev = 12'h000;
    pset = 4'h0;
    preset = 4'h0;
    for (int k = 0; k < 12; k++) if (e[k] && (k != 5 || resp_en)) exp_st[EV_BIT[k]] = 1'b1;
    exp_fl = (exp_fl & ~r) | s;
  endtask
  // hang guard
  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    conclude();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    base = 20'($random(seed));
    cfg(1'b0, 4'h0, 32'h0);
    check("cfg_reset", rd_v, 32'hFF040100);
    rnd = $random(seed);
    cfg(1'b1, 4'h0, rnd);
    cfg(1'b1, 4'hF, ~rnd);
    cfg(1'b0, 4'h0, 32'h0);
    check("cfg_line", rd_v, {24'hFF0401, rnd[7:0]});
    $display("test cfg done");
    mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
    check("status_reset", rd_v, 32'h0);
    check("rvalid", 32'(got), 32'h1);
    pci_host_model_i.xfer(1'b0, 1'b0, {base ^ 20'h00001, 10'(`STATUS_OFS >> 2)}, 4'h0, 32'h0, rd_v, got);
    check("base_miss", 32'(got), 32'h0);
    mem(1'b0, 12'h200, 4'h0, 32'h0);
    check("unmapped", rd_v, 32'h0);
    $display("test window done");
    for (int i = 0; i < 13; i++) begin
      resp_en = (i != 12);
      rnd = $random(seed);
      run = rnd[0];
      pulse((i == 12) ? 12'h060 : 12'h001 << i, 4'h0, 4'h0);
      check("dma_stop", 32'(stop_seen), 32'(i == 5));
      mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
      check("status_event", rd_v, stat_word(exp_st, exp_fl, run));
      mem(1'b1, `STATUS_OFS, 4'h0, 32'h0);
      mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
      check("status_keep", rd_v, stat_word(exp_st, exp_fl, run));
      mem(1'b1, `STATUS_OFS, 4'h0, rd_v);
      exp_st = 24'h000000;
      mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
      check("status_clear", rd_v, stat_word(exp_st, exp_fl, run));
    end
    $display("test events done");
    mem(1'b1, `MASK_OFS, 4'h0, 32'h00FFFFFF);
    for (int i = 0; i < 6; i++) begin
      rnd = $random(seed);
      pulse(12'h000, rnd[3:0], rnd[7:4]);
      mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
      check("prog_flags", rd_v, stat_word(exp_st, exp_fl, run));
      check("flags_no_irq", 32'(inta_oe_n), 32'h1);
    end
    $display("test flags done");
    mem(1'b1, `MASK_OFS, 4'h0, 32'h0);
    pulse(12'h400, 4'h0, 4'h0);
    @(negedge clk_i);
    check("masked", 32'(inta_oe_n), 32'h1);
    rnd = $random(seed);
    mem(1'b1, `MASK_OFS, 4'b1101, rnd | 32'h00000800);
    @(negedge clk_i);
    repeat (3) begin
      check("irq_on", 32'(inta_oe_n), 32'h0);
      check("inta", 32'(inta), 32'h0);
      @(negedge clk_i);
    end
    mem(1'b0, `MASK_OFS, 4'h0, 32'h0);
    check("mask_lanes", rd_v, {16'h0000, rnd[15:8] | 8'h08, 8'h00});
    mem(1'b1, `STATUS_OFS, 4'h0, 32'h00000800);
    exp_st[11] = 1'b0;
    @(negedge clk_i);
    check("irq_off", 32'(inta_oe_n), 32'h1);
    $display("test irq done");
    pulse(12'h200, 4'h0, 4'h0);
    fork
      mem(1'b1, `STATUS_OFS, 4'h0, 32'h00001000);
      pulse(12'h200, 4'h0, 4'h0);
    join
    mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
    check("set_wins", rd_v, stat_word(exp_st, exp_fl, run));
    $display("test set_wins done");
    @(negedge clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check("reset_oe", 32'(inta_oe_n), 32'h1);
    srst_i = 1'b0;
    exp_st = 24'h000000;
    exp_fl = 4'h0;
    cfg(1'b0, 4'h0, 32'h0);
    check("line_reset", rd_v, 32'hFF040100);
    mem(1'b0, `MASK_OFS, 4'h0, 32'h0);
    check("mask_reset", rd_v, 32'h0);
    mem(1'b0, `STATUS_OFS, 4'h0, 32'h0);
    check("status_reset2", rd_v, stat_word(exp_st, exp_fl, run));
    $display("test reset done");
    conclude();
  end
endmodule // pci_interrupt_status_regs_tb_top
